// *** rtl/port_route_lookup.v ***
// Default sequential routing of one port number to its companion index
`timescale 1ns/1ps
`default_nettype none
module port_route_lookup
(
    input  wire [3:0] port_idx_in,
    input  wire [3:0] per_companion_in,
    output wire [3:0] companion_out
);
    reg [3:0] acc;
    reg [3:0] cnt;
    integer   i;
    // Repeated subtraction avoids a divider; port numbers are 0-based
    always @*
    begin
        acc = port_idx_in;
        cnt = 4'h0;
        for (i = 0; i < 15; i = i + 1)
        begin
            if (per_companion_in != 4'h0 && acc >= per_companion_in)
            begin
                acc = acc - per_companion_in;
                cnt = cnt + 4'h1;
            end
        end
    end
    assign companion_out = cnt;
endmodule
`default_nettype wire

// *** rtl/struct_params_defs.vh ***
// Constants for the structural parameter register of the host controller
`ifndef STRUCT_PARAMS_DEFS_VH
`define STRUCT_PARAMS_DEFS_VH
`define SP_OFFSET        8'h04
`define SP_CC_LSB        12
`define SP_PCC_LSB       8
`define SP_ROUTE_BIT     7
`define SP_POWER_BIT     4
`define SP_PORTS_LSB     0
`define SP_CC_RESET      4'h2
`define SP_PCC_RESET     4'h1
`define SP_ROUTE_RESET   1'h1
`define SP_POWER_RESET   1'h1
`define SP_PORTS_RESET   4'h2
`endif

// *** rtl/struct_params_reg.v ***
// Read-only structural parameter register with default port routing
`timescale 1ns/1ps
`include "struct_params_defs.vh"
`default_nettype none
module struct_params_reg
#(
    parameter [3:0] COMPANIONS = `SP_CC_RESET,
    parameter [3:0] PER_COMP   = `SP_PCC_RESET,
    parameter [3:0] PORTS      = `SP_PORTS_RESET,
    parameter       ROUTE_EXPL = `SP_ROUTE_RESET,
    parameter       POWER_SW   = `SP_POWER_RESET
)
(
    input  wire        core_clk_in,
    input  wire        nrst_in,
    input  wire        rd_en_in,
    input  wire        wr_en_in,
    input  wire [7:0]  addr_in,
    input  wire [31:0] wdata_in,
    input  wire [3:0]  route_port_in,
    output wire [31:0] rdata_out,
    output wire        handoff_supported_out,
    output wire        power_switch_present_out,
    output wire        routing_method_out,
    output wire [3:0]  route_companion_out
);

    // ------------------------------------------------------------------
    // Build-time sanitising of the structural constants
    // ------------------------------------------------------------------

    // Zero port count is illegal, so it is forced to one
    localparam [3:0] PORTS_SAFE = (PORTS == 4'h0) ? 4'h1 : PORTS;

    // Product kept at eight bits so that 4 x 4 cannot wrap to zero
    localparam [7:0] PCC_SPAN = {4'h0, PER_COMP} * {4'h0, COMPANIONS};

    // Keep coverage complete: raise per-companion so companions span ports
    localparam [3:0] PCC_SAFE =
        (COMPANIONS == 4'h0) ? PER_COMP :
        (PCC_SPAN >= {4'h0, PORTS_SAFE}) ? PER_COMP : PORTS_SAFE;

    // Number of entries in the default routing table
    localparam       N_ENTRIES = 16;

    // ------------------------------------------------------------------
    // Field registers
    // ------------------------------------------------------------------

    // The fields sit in flip-flops loaded at reset so that every
    // data output except the combinational route_companion_out comes from a register, never from a raw constant.
    reg  [3:0]  companion_count_ff;
    reg  [3:0]  ports_per_companion_ff;
    reg         routing_method_ff;
    reg         power_switch_present_ff;
    reg  [3:0]  port_count_ff;
    reg         handoff_ff;

    wire [3:0]  nxt_companion_count;
    wire [3:0]  nxt_ports_per_companion;
    wire        nxt_routing_method;
    wire        nxt_power_switch_present;
    wire [3:0]  nxt_port_count;
    wire        nxt_handoff;

    // Read path
    reg  [31:0] rdata_ff;
    wire [31:0] nxt_rdata;
    wire [31:0] sp_word;
    wire        rd_hit;

    // Default routing table, one nibble per port number
    wire [4*N_ENTRIES-1:0] route_tbl;

    // ------------------------------------------------------------------
    // Field next values
    // ------------------------------------------------------------------

    // Nothing but reset ever changes a field: the write strobe and the
    // write data have no path into these registers at all.
    assign nxt_companion_count      = companion_count_ff;
    assign nxt_ports_per_companion  = ports_per_companion_ff;
    assign nxt_routing_method       = routing_method_ff;
    assign nxt_power_switch_present = power_switch_present_ff;
    assign nxt_port_count           = port_count_ff;
    assign nxt_handoff              = handoff_ff;

    always @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            companion_count_ff      <= COMPANIONS;
            ports_per_companion_ff  <= PCC_SAFE;
            routing_method_ff       <= ROUTE_EXPL[0];
            power_switch_present_ff <= POWER_SW[0];
            port_count_ff           <= PORTS_SAFE;
            handoff_ff              <= (COMPANIONS != 4'h0);
        end
        else
        begin
            companion_count_ff      <= nxt_companion_count;
            ports_per_companion_ff  <= nxt_ports_per_companion;
            routing_method_ff       <= nxt_routing_method;
            power_switch_present_ff <= nxt_power_switch_present;
            port_count_ff           <= nxt_port_count;
            handoff_ff              <= nxt_handoff;
        end
    end

    // ------------------------------------------------------------------
    // Word assembly
    // ------------------------------------------------------------------

    // Reserved bits are tied low here rather than left to the read mux,
    // so a later field added next to them cannot leak into them.
    assign sp_word[31:16] = 16'h0000;
    assign sp_word[15:12] = companion_count_ff;
    assign sp_word[11:8]  = ports_per_companion_ff;
    assign sp_word[7]     = routing_method_ff;
    assign sp_word[6:5]   = 2'h0;
    assign sp_word[4]     = power_switch_present_ff;
    assign sp_word[3:0]   = port_count_ff;

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------

    // Only a read strobe at the word's own offset selects it; a write
    // strobe, alone or together with a read, is simply not decoded.
    assign rd_hit = rd_en_in && (addr_in == `SP_OFFSET);

    // Per-bit gating keeps the idle bus at zero between reads
    genvar b;
    generate
        for (b = 0; b < 32; b = b + 1)
        begin : g_rd_bit
            assign nxt_rdata[b] = rd_hit & sp_word[b];
        end
    endgenerate

    // Reads have no side effect: the answer register is the only state
    // that a read touches, and it is rebuilt from scratch every cycle.
    always @(posedge core_clk_in)
    begin
        if (!nrst_in)
            rdata_ff <= 32'h00000000;
        else
            rdata_ff <= nxt_rdata;
    end

    // ------------------------------------------------------------------
    // Default sequential routing table
    // ------------------------------------------------------------------

    // One lookup per port number; the table covers every index that the
    // four-bit port field can express, so no lookup ever falls off it.
    // Explicit routing is not built here: the table only describes the
    // sequential grouping, whatever the routing method bit says.
    genvar g;
    generate
        for (g = 0; g < N_ENTRIES; g = g + 1)
        begin : g_route
            port_route_lookup u_port_route_lookup
            (
                .port_idx_in      (g[3:0]),
                .per_companion_in (ports_per_companion_ff),
                .companion_out    (route_tbl[4*g +: 4])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    assign rdata_out                = rdata_ff;
    assign handoff_supported_out    = handoff_ff;
    assign power_switch_present_out = power_switch_present_ff;
    assign routing_method_out       = routing_method_ff;

    // Port lookup is combinational so software sees the group at once
    assign route_companion_out = route_tbl[{route_port_in, 2'b00} +: 4];

    // ------------------------------------------------------------------
    // Limitations
    // ------------------------------------------------------------------

    // The write strobe and write data are accepted only to keep the
    // register port complete; the word is read-only, so both are
    // deliberately left without a load.
    // A companion count of zero leaves the per-companion value as given;
    // the routing table is then meaningless and hand-off stays off.
    // Port numbers beyond the port count still map through the table;
    // callers that care must range-check against the port field.

endmodule
`default_nettype wire

// *** verif/struct_params_properties.sv ***
// Assertions for the structural parameter register
`timescale 1ns/1ps
`default_nettype none
module struct_params_props (
    input wire logic        core_clk_in, nrst_in, rd_en_in,
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] rdata_out,
    input wire logic [3:0]  route_port_in, route_companion_out,
    input wire logic        handoff_supported_out, power_switch_present_out,
    input wire logic        routing_method_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    chk_word_read: assert property (rd_en_in && addr_in == 8'h04
        |=> rdata_out == 32'h00002192) else $error("bad word");
    chk_idle_zero: assert property (!(rd_en_in && addr_in == 8'h04)
        |=> rdata_out == 32'h0) else $error("data not zero");
    chk_handoff_on: assert property (handoff_supported_out)
        else $error("no handoff");
    chk_power_bit: assert property (power_switch_present_out)
        else $error("no power bit");
    chk_route_bit: assert property (routing_method_out)
        else $error("route bit");
    chk_route_map: assert property (route_companion_out == route_port_in)
        else $error("bad route");
    chk_ports_nonzero: assert property (|rdata_out
        |-> rdata_out[3:0] != 4'h0) else $error("zero ports");
    chk_comp_count: assert property (|rdata_out
        |-> rdata_out[15:8] == 8'h21) else $error("bad counts");
endmodule
bind struct_params_reg struct_params_props u_struct_params_props (.*);
`default_nettype wire

// *** verif/struct_params_reg_tb_top.sv ***
// Bench for the structural parameter register
`timescale 1ns/1ps
`default_nettype none
module struct_params_reg_tb_top;
    logic        core_clk_in = 0, nrst_in = 0, rd_en_in = 0, wr_en_in = 0;
    logic [7:0]  addr_in = 8'h04;
    logic [31:0] wdata_in = 32'h0, rdata_out;
    logic [3:0]  route_port_in = 4'h0, route_companion_out;
    logic        hand, pwr, rmeth;
    int          n_mismatch = 0, checks = 0;
    always #12.5 core_clk_in = ~core_clk_in;
    struct_params_reg u_struct_params_reg (.core_clk_in(core_clk_in),
        .nrst_in(nrst_in), .rd_en_in(rd_en_in), .wr_en_in(wr_en_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .route_port_in(route_port_in),
        .rdata_out(rdata_out), .handoff_supported_out(hand),
        .power_switch_present_out(pwr), .routing_method_out(rmeth),
        .route_companion_out(route_companion_out));
    task automatic cmp(input string nm, input logic [31:0] e, s);
        checks++;
        n_mismatch += (s !== e);
        if (s !== e) $display("[FAIL] %s exp %h got %h", nm, e, s);
    endtask
    // Answer lands one edge after the strobe and stands one cycle only
    task automatic rd(input logic [7:0] a, input logic w, input logic [31:0] e);
        @(negedge core_clk_in) {rd_en_in, wr_en_in, addr_in} = {1'b1, w, a};
        wdata_in = 32'hffffffff;
        @(negedge core_clk_in) {rd_en_in, wr_en_in} = 2'b00;
        cmp("rdata", e, rdata_out);
        @(negedge core_clk_in) cmp("rdata idle", 32'h0, rdata_out);
    endtask
    task automatic t_route;
        for (int p = 0; p < 4; p++)
        begin
            @(negedge core_clk_in) route_port_in = p[3:0];
            #1 cmp("route", {28'h0, p[3:0]}, {28'h0, route_companion_out});
        end
    endtask
    // Reset in mid-run drops a pending answer, then reads recover
    task automatic t_reset;
        @(negedge core_clk_in) {rd_en_in, addr_in, nrst_in} = 10'h209;
        nrst_in = 1'b0;
        @(negedge core_clk_in) rd_en_in = 1'b0;
        cmp("rdata reset", 32'h0, rdata_out);
        nrst_in = 1'b1;
        rd(8'h04, 1'b0, 32'h00002192);
    endtask
    task automatic complete_run;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge core_clk_in);
        nrst_in = 1;
        rd(8'h04, 1'b0, 32'h00002192);
        rd(8'h04, 1'b1, 32'h00002192);
        rd(8'h08, 1'b0, 32'h0);
        t_route();
        t_reset();
        cmp("flags", 32'h7, {29'h0, hand, pwr, rmeth});
        complete_run();
    end
endmodule
`default_nettype wire
